// >>> rtl/swm_cfg.svh
// Offsets, reset values and timing counts of the sleep/wake mode controller
`ifndef SWM_CFG_SVH
`define SWM_CFG_SVH
`define SWM_CTRL1_ADDR 8'h2a
`define SWM_CTRL2_ADDR 8'h2b
`define SWM_CTRL1_RESET 8'h00
`define SWM_CTRL2_RESET 8'h00
`define SWM_RST_BIT 6
`define SWM_CLK_NS 50
`define SWM_BASE_NS 1250000
`define SWM_BASE_CYC (`SWM_BASE_NS / `SWM_CLK_NS)
`define SWM_STEP_MASK 9'h0ff
`define SWM_SLOW_STEP_MASK 9'h1ff
`define SWM_SLOW_RATE 3'h7
`define SWM_BOOT_CYC 3'h4
`endif

// >>> rtl/swm_pkg.sv
// Types shared by the sleep/wake mode controller
package swm_pkg;
	typedef enum logic [1:0] {SWM_STANDBY, SWM_WAKE, SWM_SLEEP} swm_mode_t;
	typedef struct packed {
		logic [1:0] sleep_rate_sel;
		logic [2:0] wake_rate_sel;
		logic low_noise_sel;
		logic fast_read;
		logic active;
	} swm_ctrl1_t;
	typedef struct packed {
		logic self_test_en;
		logic sw_reset;
		logic unused_zero;
		logic [1:0] sleep_oversample_scheme;
		logic auto_sleep_en;
		logic [1:0] wake_oversample_scheme;
	} swm_ctrl2_t;
	typedef struct packed {
		logic freefall_motion;
		logic tap;
		logic orientation;
		logic transient;
	} swm_det_t;
endpackage

// >>> rtl/swm_mode_ctrl.sv
// Sleep/wake system mode controller with its two control registers
// Functional notes
// - Enabled transient, orientation, tap and freefall/motion events restart the inactivity timer.
// - Sleep returns to wake on an enabled event whose wake selection is set, or when automatic sleep is cleared.
// - Enabled detectors keep running in sleep at the sleep sample rate.
// - A FIFO event restarts the inactivity timer but never wakes.
// - Sleep/wake and data-ready events never touch the sleep/wake state.
// - With FIFO hold, transitions proceed; FIFO blocks new samples until emptied.
// - With automatic sleep off, only standby and wake are used.
// - Each wake/sleep transition raises the sleep/wake event when enabled.
// - Sleep rate 00/01/10/11 selects 50, 12.5, 6.25, 1.56 Hz.
// - In sleep, the sleep rate replaces system and functional block rates.
// - Wake rate 000..111 selects 800 Hz down to 1.56 Hz, default 000.
// - Active bit 0 is standby, 1 is active; resets to 0.
// - Low-noise bit limits range to 4g.
// - Fast read skips low data bytes for output registers and FIFO.
// - Writing 1 to software reset reloads all defaults in any mode.
// - Software reset also resets the serial register interface.
// - Software reset bit clears after boot and always reads zero.
// - Self-test bit offsets all axes; clear by default.
// - Oversampling schemes 00..11; wake scheme awake, sleep scheme asleep.
// - Automatic sleep enable, default 0, permits the switch to sleep rate.
// - Sleep after inactivity count steps of 320 ms, 640 ms at slowest.
// - Hold error sets on a sample while FIFO blocked, stays until emptied.
`timescale 1ns/1ps
`include "swm_cfg.svh"
module swm_mode_ctrl import swm_pkg::*; #(
	parameter int BASE_CYC = `SWM_BASE_CYC // Cycles of one 1.25 ms base tick
) (
	input wire logic CLK, // 20 MHz clock
	input wire logic RST_N, // Asynchronous reset, active low
	input wire logic REG_WE, // Register write strobe
	input wire logic REG_RE, // Register read strobe
	input wire logic [7:0] REG_ADDR, // Register address
	input wire logic [7:0] REG_WDATA, // Register write data
	input wire swm_det_t EVT, // Detection event pulses
	input wire logic FIFO_EVT, // FIFO event pulse
	input wire swm_det_t INT_EN, // Detector interrupt enables
	input wire swm_det_t WAKE_SEL, // Wake-from-sleep selections
	input wire logic ASLP_INT_EN, // Sleep/wake interrupt enable
	input wire logic [7:0] INACT_COUNT, // Inactivity count
	input wire logic FIFO_HOLD, // FIFO hold bit
	input wire logic FIFO_EMPTIED, // FIFO emptied by host
	output logic [7:0] REG_RDATA, // Register read data
	output swm_mode_t MODE, // System mode
	output logic [2:0] RATE_SEL, // Rate in force for all blocks
	output logic [1:0] OS_SCHEME, // Oversampling scheme in force
	output logic [3:0] OS_RATIO_LOG2, // Log2 of oversampling ratio
	output logic SAMPLE_TICK, // One pulse per sample
	output logic SELF_TEST, // Self-test on
	output logic LOW_NOISE_RANGE, // Range held to 4g
	output logic FAST_READ, // Skip low data bytes
	output logic SLEEP_WAKE_EVT, // Transition event pulse
	output logic FIFO_BLOCK, // FIFO ignores new samples
	output logic FIFO_HOLD_ERR, // Hold error flag
	output logic SOFT_RESET // Resets serial interface
);
	// ==========================================================
	// Reset release
	logic rst_meta, rst_n;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// State
	swm_ctrl1_t ctrl1, next_ctrl1;
	swm_ctrl2_t ctrl2, next_ctrl2;
	swm_mode_t mode, next_mode;
	logic [15:0] base_cnt, next_base_cnt;
	logic [8:0] pre_cnt, next_pre_cnt;
	logic [7:0] inact_steps, next_inact_steps;
	logic [2:0] boot_cnt, next_boot_cnt;
	logic [7:0] next_rdata;
	logic [2:0] rate, next_rate;
	logic [1:0] next_os;
	logic [3:0] next_ratio;
	logic next_tick, next_evt, next_block, next_err;
	logic base_tick, step_tick, swrst_go, activity, wake_hit;
	logic [8:0] rate_mask, step_mask;

	always_comb begin
		next_ctrl1 = ctrl1;
		next_ctrl2 = ctrl2;
		next_mode = mode;
		next_inact_steps = inact_steps;
		next_boot_cnt = (boot_cnt != 3'h0) ? boot_cnt - 3'h1 : 3'h0;
		next_rdata = REG_RDATA;
		next_evt = 1'b0;
		// Emptying lifts the block; a transition with FIFO hold set in the same cycle sets it again
		next_block = FIFO_BLOCK && !FIFO_EMPTIED;
		swrst_go = REG_WE && (boot_cnt == 3'h0) && (REG_ADDR == `SWM_CTRL2_ADDR)
			&& REG_WDATA[`SWM_RST_BIT];
		// sleep codes map onto the four slowest rate codes
		// sleep rate overrides the wake rate
		rate = (mode == SWM_SLEEP) ? {1'b1, ctrl1.sleep_rate_sel} : ctrl1.wake_rate_sel;
		next_rate = rate;
		next_os = (mode == SWM_SLEEP) ? ctrl2.sleep_oversample_scheme
			: ctrl2.wake_oversample_scheme;
		case (rate)
			3'h0: rate_mask = 9'h000;
			3'h1: rate_mask = 9'h001;
			3'h2: rate_mask = 9'h003;
			3'h3: rate_mask = 9'h007;
			3'h4: rate_mask = 9'h00f;
			3'h5: rate_mask = 9'h03f;
			3'h6: rate_mask = 9'h07f;
			default: rate_mask = 9'h1ff;
		endcase
		// inactivity step doubles at the slowest rate
		step_mask = (rate == `SWM_SLOW_RATE) ? `SWM_SLOW_STEP_MASK : `SWM_STEP_MASK;
		base_tick = (base_cnt == 16'(BASE_CYC - 1));
		next_base_cnt = base_tick ? 16'h0000 : base_cnt + 16'h0001;
		next_pre_cnt = base_tick ? pre_cnt + 9'h001 : pre_cnt;
		// every detector samples on this tick, in sleep too
		next_tick = base_tick && ((pre_cnt & rate_mask) == 9'h000);
		step_tick = base_tick && ((pre_cnt & step_mask) == 9'h000);
		// the four detector events count as activity when their interrupt is enabled
		// FIFO events restart the timer but are kept out of the wake term
		// sleep/wake and data-ready events are not inputs here at all
		activity = |(EVT & INT_EN) || FIFO_EVT;
		// wake needs interrupt enable and wake selection both
		wake_hit = |(EVT & INT_EN & WAKE_SEL);
		case (mode)
			SWM_STANDBY: begin
				next_inact_steps = 8'h00;
				if (ctrl1.active) begin
					next_mode = SWM_WAKE;
				end
			end
			SWM_WAKE: begin
				if (!ctrl1.active) begin
					next_mode = SWM_STANDBY;
					next_inact_steps = 8'h00;
				// no sleep without automatic sleep enabled
				end else if (!ctrl2.auto_sleep_en || activity) begin
					next_inact_steps = 8'h00;
				end else if (step_tick) begin
					// sleep once the programmed count has elapsed
					if (inact_steps >= INACT_COUNT) begin
						next_mode = SWM_SLEEP;
						next_inact_steps = 8'h00;
					end else begin
						next_inact_steps = inact_steps + 8'h01;
					end
				end
			end
			SWM_SLEEP: begin
				if (!ctrl1.active) begin
					next_mode = SWM_STANDBY;
				end else if (wake_hit || !ctrl2.auto_sleep_en) begin
					next_mode = SWM_WAKE;
				end
			end
			default: next_mode = SWM_STANDBY;
		endcase
		if ((mode != SWM_STANDBY) && (next_mode != SWM_STANDBY) && (next_mode != mode)) begin
			next_evt = ASLP_INT_EN;
			// hold keeps FIFO contents across the transition
			next_block = FIFO_HOLD || next_block;
		end
		// a sample while blocked raises the error; set beats clear
		next_err = (FIFO_BLOCK && next_tick) || (FIFO_HOLD_ERR && !FIFO_EMPTIED);
		// Writes are dropped during boot so a half access cannot land
		if (REG_WE && (boot_cnt == 3'h0)) begin
			if (REG_ADDR == `SWM_CTRL1_ADDR) begin
				next_ctrl1 = swm_ctrl1_t'(REG_WDATA);
			end else if (REG_ADDR == `SWM_CTRL2_ADDR) begin
				next_ctrl2 = swm_ctrl2_t'(REG_WDATA);
				next_ctrl2.unused_zero = 1'b0;
				next_ctrl2.sw_reset = 1'b0;
			end
		end
		if (REG_RE) begin
			// reset bit and bit 5 always read zero
			case (REG_ADDR)
				`SWM_CTRL1_ADDR: next_rdata = ctrl1;
				`SWM_CTRL2_ADDR: next_rdata = ctrl2;
				default: next_rdata = 8'h00;
			endcase
		end
		if (swrst_go) begin
			next_ctrl1 = swm_ctrl1_t'(`SWM_CTRL1_RESET);
			next_ctrl2 = swm_ctrl2_t'(`SWM_CTRL2_RESET);
			next_mode = SWM_STANDBY;
			next_inact_steps = 8'h00;
			next_evt = 1'b0;
			next_block = 1'b0;
			next_err = 1'b0;
			// boot window resets the serial interface
			next_boot_cnt = `SWM_BOOT_CYC;
		end
	end

	// ==========================================================
	// Oversampling ratio lookup, log2 coded
	// entries for some scheme and rate pairs, default for the rest
	always_comb begin
		case ({next_os, rate})
			5'h00: next_ratio = 4'h1;
			5'h05: next_ratio = 4'h4;
			5'h06: next_ratio = 4'h5;
			5'h07: next_ratio = 4'h7;
			5'h08: next_ratio = 4'h1;
			5'h0d: next_ratio = 4'h2;
			5'h0e: next_ratio = 4'h3;
			5'h0f: next_ratio = 4'h5;
			5'h10: next_ratio = 4'h1;
			5'h11: next_ratio = 4'h2;
			5'h12: next_ratio = 4'h3;
			5'h13: next_ratio = 4'h4;
			5'h14: next_ratio = 4'h5;
			5'h15: next_ratio = 4'h7;
			5'h16: next_ratio = 4'h8;
			5'h17: next_ratio = 4'ha;
			5'h1e: next_ratio = 4'h2;
			5'h1f: next_ratio = 4'h4;
			default: next_ratio = (next_os == 2'h3) ? 4'h1 : 4'h2;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1 <= swm_ctrl1_t'(`SWM_CTRL1_RESET);
			ctrl2 <= swm_ctrl2_t'(`SWM_CTRL2_RESET);
			mode <= SWM_STANDBY;
			base_cnt <= 16'h0000;
			pre_cnt <= 9'h000;
			inact_steps <= 8'h00;
			boot_cnt <= 3'h0;
			REG_RDATA <= 8'h00;
			RATE_SEL <= 3'h0;
			OS_SCHEME <= 2'h0;
			OS_RATIO_LOG2 <= 4'h1;
			SAMPLE_TICK <= 1'b0;
			SLEEP_WAKE_EVT <= 1'b0;
			FIFO_BLOCK <= 1'b0;
			FIFO_HOLD_ERR <= 1'b0;
			SOFT_RESET <= 1'b0;
		end else begin
			ctrl1 <= next_ctrl1;
			ctrl2 <= next_ctrl2;
			mode <= next_mode;
			base_cnt <= next_base_cnt;
			pre_cnt <= next_pre_cnt;
			inact_steps <= next_inact_steps;
			boot_cnt <= next_boot_cnt;
			REG_RDATA <= next_rdata;
			RATE_SEL <= next_rate;
			OS_SCHEME <= next_os;
			OS_RATIO_LOG2 <= next_ratio;
			SAMPLE_TICK <= next_tick;
			SLEEP_WAKE_EVT <= next_evt;
			FIFO_BLOCK <= next_block;
			FIFO_HOLD_ERR <= next_err;
			SOFT_RESET <= (next_boot_cnt != 3'h0);
		end
	end

	assign MODE = mode;
	// self-test, 4g limit, fast read, straight from flops
	assign SELF_TEST = ctrl2.self_test_en;
	assign LOW_NOISE_RANGE = ctrl1.low_noise_sel;
	assign FAST_READ = ctrl1.fast_read;

	// ==========================================================
	// Assertions
	sequence s_swrst;
		swrst_go;
	endsequence
	sequence s_boot;
		SOFT_RESET [*4] ##1 !SOFT_RESET;
	endsequence
	a_standby_follows: assert property (@(posedge CLK) disable iff (!rst_n)
		!ctrl1.active |=> mode == SWM_STANDBY) else $error("standby not taken");
	a_no_auto_sleep: assert property (@(posedge CLK) disable iff (!rst_n)
		!ctrl2.auto_sleep_en |=> mode != SWM_SLEEP) else $error("slept while disabled");
	a_wake_needs_sel: assert property (@(posedge CLK) disable iff (!rst_n)
		(mode == SWM_SLEEP && !wake_hit && ctrl2.auto_sleep_en && ctrl1.active && !swrst_go)
		|=> mode == SWM_SLEEP) else $error("woke without selected event");
	a_activity_restart: assert property (@(posedge CLK) disable iff (!rst_n)
		(mode == SWM_WAKE && activity) |=> inact_steps == 8'h00 && mode != SWM_SLEEP)
		else $error("activity did not restart timer");
	a_transition_event: assert property (@(posedge CLK) disable iff (!rst_n)
		(mode == SWM_WAKE && ASLP_INT_EN && !swrst_go) ##1 mode == SWM_SLEEP
		|-> SLEEP_WAKE_EVT) else $error("missing transition event");
	a_return_event: assert property (@(posedge CLK) disable iff (!rst_n)
		(mode == SWM_SLEEP && ASLP_INT_EN && !swrst_go) ##1 mode == SWM_WAKE
		|-> SLEEP_WAKE_EVT) else $error("missing return event");
	a_sleep_rate: assert property (@(posedge CLK) disable iff (!rst_n)
		mode == SWM_SLEEP |=> RATE_SEL == {1'b1, $past(ctrl1.sleep_rate_sel)})
		else $error("sleep rate not applied");
	a_rst_bit_zero: assert property (@(posedge CLK) disable iff (!rst_n)
		(REG_RE && REG_ADDR == `SWM_CTRL2_ADDR) |=> !REG_RDATA[`SWM_RST_BIT])
		else $error("reset bit read as one");
	a_swrst_defaults: assert property (@(posedge CLK) disable iff (!rst_n)
		s_swrst |=> ctrl1 == 8'h00 && ctrl2 == 8'h00 && mode == SWM_STANDBY)
		else $error("defaults not reloaded");
	a_boot_window: assert property (@(posedge CLK) disable iff (!rst_n)
		s_swrst |=> s_boot) else $error("boot window wrong length");
	a_hold_error: assert property (@(posedge CLK) disable iff (!rst_n)
		(FIFO_BLOCK && next_tick && !swrst_go) |=> FIFO_HOLD_ERR)
		else $error("hold error not raised");
endmodule // swm_mode_ctrl

// >>> bench/swm_host_model.sv
// Host model issuing single-byte register accesses to the mode controller
`timescale 1ns/1ps
module swm_host_model (
	input wire logic clk, // Device clock
	output logic reg_we, // Write strobe
	output logic reg_re, // Read strobe
	output logic [7:0] reg_addr, // Register address
	output logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata // Read data
);
	logic [7:0] shadow1;
	initial begin
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		shadow1 = 8'h00;
	end
	// ==========================================
	// Bus cycles
	// Released address and data show the inverse so stale values never pass
	task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = w;
		reg_re = !w;
		@(negedge clk);
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h2a && shadow1[0] && d[7:1] != shadow1[7:1]) begin
			cyc(a, {shadow1[7:1], 1'b0}, 1'b1);
		end
		cyc(a, d, 1'b1);
		if (a == 8'h2a) begin
			shadow1 = d;
		end
		if (a == 8'h2b && d[6]) begin
			shadow1 = 8'h00;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cyc(a, 8'h00, 1'b0);
		d = reg_rdata;
	endtask
endmodule // swm_host_model

// >>> bench/tb.sv
// Self-checking testbench for the sleep/wake mode controller
`timescale 1ns/1ps
module tb import swm_pkg::*;;
	logic clk, rst_n, fifo_evt, aslp_en, hold, emptied, we, re;
	swm_det_t evt, int_en, wake_sel;
	logic [7:0] inact, rdv, addr, wdata, rdata;
	swm_mode_t mode;
	logic [2:0] rate;
	logic [1:0] scheme;
	logic [3:0] ratio;
	logic st, ln, fr, swe, blk, herr, srst, tick;
	int n_mismatch, checks;
	logic [3:0] exp_ratio [4] = '{4'h2, 4'h2, 4'h8, 4'h4};

	swm_host_model host_u (.clk(clk), .reg_we(we), .reg_re(re), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata));
	// Short base tick keeps each inactivity step near a thousand cycles
	swm_mode_ctrl #(.BASE_CYC(4)) dut_u (.CLK(clk), .RST_N(rst_n), .REG_WE(we), .REG_RE(re),
		.REG_ADDR(addr), .REG_WDATA(wdata), .EVT(evt), .FIFO_EVT(fifo_evt), .INT_EN(int_en),
		.WAKE_SEL(wake_sel), .ASLP_INT_EN(aslp_en), .INACT_COUNT(inact), .FIFO_HOLD(hold),
		.FIFO_EMPTIED(emptied), .REG_RDATA(rdata), .MODE(mode), .RATE_SEL(rate),
		.OS_SCHEME(scheme), .OS_RATIO_LOG2(ratio), .SAMPLE_TICK(tick), .SELF_TEST(st),
		.LOW_NOISE_RANGE(ln), .FAST_READ(fr), .SLEEP_WAKE_EVT(swe), .FIFO_BLOCK(blk),
		.FIFO_HOLD_ERR(herr), .SOFT_RESET(srst));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================
	// Helpers
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			evt = 4'h0;
			fifo_evt = 1'b0;
			emptied = 1'b0;
		end
	endtask
	task automatic pulse(input logic [3:0] e, input logic f, input logic m);
		@(negedge clk);
		evt = e;
		fifo_evt = f;
		emptied = m;
	endtask
	task automatic wait_mode(input swm_mode_t m, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			idle(1);
			if (mode === m) begin
				break;
			end
		end
		if (k == n) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic wait_tick(input int n, output int k);
		for (k = 0; k < n; k++) begin
			idle(1);
			if (tick === 1'b1) begin
				break;
			end
		end
		if (k == n) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		host_u.rd(8'h2a, rdv);
		chk(rdv, 8'h00);
		host_u.rd(8'h2b, rdv);
		chk(rdv, 8'h00);
		host_u.rd(8'h30, rdv);
		chk(rdv, 8'h00);
		chk({6'h0, mode}, 8'(SWM_STANDBY));
		host_u.wr(8'h2b, 8'hbf);
		host_u.rd(8'h2b, rdv);
		chk(rdv, 8'h9f);
		chk({7'h0, st}, 8'h01);
		host_u.wr(8'h2a, 8'h07);
		idle(3);
		chk({5'h0, ln, fr, 1'b0}, 8'h06);
		chk({6'h0, mode}, 8'(SWM_WAKE));
		host_u.wr(8'h2b, 8'h40);
		idle(1);
		chk({7'h0, srst}, 8'h01);
		chk({6'h0, mode}, 8'(SWM_STANDBY));
		// A write inside the boot window must be dropped
		host_u.wr(8'h2a, 8'h01);
		idle(6);
		host_u.rd(8'h2a, rdv);
		chk(rdv, 8'h00);
		host_u.rd(8'h2b, rdv);
		chk(rdv, 8'h00);
		chk({7'h0, st}, 8'h00);
	endtask
	task automatic t_rates();
		for (int c = 0; c < 8; c++) begin
			host_u.wr(8'h2a, {2'h0, 3'(c), 3'h1});
			idle(3);
			chk({6'h0, mode}, 8'(SWM_WAKE));
			chk({5'h0, rate}, 8'(c));
			host_u.wr(8'h2a, 8'h00);
			idle(2);
			chk({6'h0, mode}, 8'(SWM_STANDBY));
		end
	endtask
	task automatic t_sleep();
		int g;
		for (int i = 0; i < 4; i++) begin
			hold = (i == 0);
			host_u.wr(8'h2b, {3'h0, 2'(i), 1'b1, 2'h0});
			host_u.wr(8'h2a, {2'(i), 3'h0, 3'h1});
			wait_mode(SWM_SLEEP, 2200);
			chk({7'h0, swe}, 8'h01);
			idle(3);
			chk({5'h0, rate}, 8'(4 + i));
			chk({6'h0, scheme}, 8'(i));
			chk({4'h0, ratio}, {4'h0, exp_ratio[i]});
			if (i == 0) begin
				chk({7'h0, blk}, 8'h01);
				idle(80);
				chk({7'h0, herr}, 8'h01);
				// Empty just after a sample so no new sample meets the clear
				wait_tick(600, g);
				pulse(4'h0, 1'b0, 1'b1);
				idle(3);
				chk({6'h0, blk, herr}, 8'h00);
				wait_tick(600, g);
				wait_tick(600, g);
				chk(8'(g + 1), 8'h40);
				hold = 1'b0;
			end
			int_en = 4'hf;
			wake_sel = ~(4'h1 << i);
			pulse(4'h1 << i, 1'b1, 1'b0);
			idle(4);
			chk({6'h0, mode}, 8'(SWM_SLEEP));
			// Last pass checks that a disabled transition event stays quiet
			aslp_en = (i != 3);
			wake_sel = 4'h1 << i;
			pulse(4'h1 << i, 1'b0, 1'b0);
			wait_mode(SWM_WAKE, 4);
			chk({7'h0, swe}, 8'(i != 3));
			aslp_en = 1'b1;
			host_u.wr(8'h2a, 8'h00);
		end
	endtask
	task automatic t_active();
		host_u.wr(8'h2b, 8'h04);
		inact = 8'h01;
		host_u.wr(8'h2a, 8'h01);
		for (int k = 0; k < 20; k++) begin
			pulse((k % 5 == 4) ? 4'h0 : 4'h1 << (k % 5), k % 5 == 4, 1'b0);
			idle(150);
			chk({6'h0, mode}, 8'(SWM_WAKE));
		end
		host_u.wr(8'h2a, 8'h00);
	endtask
	task automatic t_nosleep();
		host_u.wr(8'h2b, 8'h00);
		host_u.wr(8'h2a, 8'h01);
		idle(2200);
		chk({6'h0, mode}, 8'(SWM_WAKE));
		chk({4'h0, ratio}, 8'h01);
		host_u.wr(8'h2a, 8'h00);
	endtask
	initial begin
		n_mismatch = 0;
		checks = 0;
		rst_n = 1'b0;
		evt = 4'h0;
		fifo_evt = 1'b0;
		int_en = 4'h0;
		wake_sel = 4'h0;
		aslp_en = 1'b1;
		inact = 8'h00;
		hold = 1'b0;
		emptied = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		idle(3);
		t_regs();
		t_rates();
		t_sleep();
		t_active();
		t_nosleep();
		report_and_stop();
	end
endmodule // tb
